// ---- jtip_pkg.sv ----
// Constants and types shared by the test access port and its row memory
// Contract
// - Bypass puts one-bit register in scan path
// - Bypass passes scan data, user logic unaffected
// - Identification code selects identification register
// - Serial input sampled on test clock rise
// - Serial output changes on test clock fall
// - Serial output released when not shifting
// - No test reset pin; power-up reset used
// - Instruction subset, but chain member works
// - Factory state: pins act as test port
// - Macrocells behind port pins stay buried logic
// - Configuration may turn pins into plain I/O
// - Array erased and programmed through port
// - Arm, erase, program, verify use programming register
package jtip_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int PRG_W = ADDR_W + DATA_W;
  localparam int ROWS = 16;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_ENABLE = 4'h9;
  localparam logic [IR_W-1:0] IR_ERASE = 4'ha;
  localparam logic [IR_W-1:0] IR_PROGRAM = 4'hb;
  localparam logic [IR_W-1:0] IR_VERIFY = 4'hc;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET_VAL = IR_IDCODE;

  // Arbitrary identification value; bit 0 set as scan chains expect
  localparam logic [ID_W-1:0] IDCODE_VAL = 32'h0a5c_0001;

  // ----------------------------------------------------------------
  // Array layout and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] ROW_ERASED = 16'h0000;
  localparam logic [ADDR_W-1:0] CFG_ROW = 4'h0;
  localparam int CFG_BIT = 0;
  localparam logic [ID_W-1:0] DR_RESET_VAL = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int PWE_MS = 100;
  localparam int PWP_MS = 10;
  localparam int unsigned ERASE_CYC = PWE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PROG_CYC = PWP_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TS_RESET  = 16'h0001,
    TS_IDLE   = 16'h0002,
    TS_SEL_DR = 16'h0004,
    TS_CAP_DR = 16'h0008,
    TS_SH_DR  = 16'h0010,
    TS_EX1_DR = 16'h0020,
    TS_PA_DR  = 16'h0040,
    TS_EX2_DR = 16'h0080,
    TS_UP_DR  = 16'h0100,
    TS_SEL_IR = 16'h0200,
    TS_CAP_IR = 16'h0400,
    TS_SH_IR  = 16'h0800,
    TS_EX1_IR = 16'h1000,
    TS_PA_IR  = 16'h2000,
    TS_EX2_IR = 16'h4000,
    TS_UP_IR  = 16'h8000
  } jtip_tap_t;

  typedef enum logic [2:0] {
    DS_BYP = 3'h1,
    DS_ID  = 3'h2,
    DS_PRG = 3'h4
  } jtip_dsel_t;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'h1,
    OP_ERASE = 3'h2,
    OP_PROG  = 3'h4
  } jtip_op_t;

endpackage : jtip_pkg

// ---- jtip_mem_if.sv ----
// Signals between the port controller and the configuration row memory
`timescale 1ns/1ns
`default_nettype none
interface jtip_mem_if;
  import jtip_pkg::*;
  logic we;
  logic erase;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic cfg_off;
  modport ctl (output we, erase, wr_addr, wr_data, rd_addr,
               input rd_data, cfg_off);
  modport mem (input we, erase, wr_addr, wr_data, rd_addr,
               output rd_data, cfg_off);
endinterface : jtip_mem_if
`default_nettype wire

// ---- jtip_row_mem.sv ----
// Configuration row memory with registered read and whole-array erase
`timescale 1ns/1ns
`default_nettype none
module jtip_row_mem (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Controller side
  jtip_mem_if.mem bus
);
  import jtip_pkg::*;

  logic [DATA_W-1:0] rows_r [ROWS];
  logic [DATA_W-1:0] rd_data_r;
  logic cfg_off_r;

  // ----------------------------------------------------------------
  // Rows
  // ----------------------------------------------------------------
  // Reset stands in for the factory-erased array in simulation
  for (genvar i = 0; i < ROWS; i++) begin : g_row
    always_ff @(posedge mclk_in) begin
      if (rst_in || bus.erase) begin
        rows_r[i] <= ROW_ERASED;
      end else if (bus.we && bus.wr_addr == ADDR_W'(i)) begin
        rows_r[i] <= bus.wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_data_r <= ROW_ERASED;
      cfg_off_r <= 1'b0;
    end else begin
      rd_data_r <= rows_r[bus.rd_addr];
      cfg_off_r <= rows_r[CFG_ROW][CFG_BIT];
    end
  end

  assign bus.rd_data = rd_data_r;
  assign bus.cfg_off = cfg_off_r;

endmodule : jtip_row_mem
`default_nettype wire

// ---- jtip_top.sv ----
// Test access port with bypass, identification and array programming
`timescale 1ns/1ns
`default_nettype none
module jtip_top #(
  parameter int unsigned ERASE_CYC = jtip_pkg::ERASE_CYC,
  parameter int unsigned PROG_CYC = jtip_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Port pins
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Status
  output logic port_jtag_out,
  output logic hv_pump_on_out
);
  import jtip_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit 0 clock, bit 1 mode select, bit 2 serial input
  logic [2:0] sync_a_r;
  logic [2:0] sync_b_r;
  logic tck_d_r;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sync_a_r <= 3'h0;
      sync_b_r <= 3'h0;
      tck_d_r <= 1'b0;
    end else begin
      sync_a_r <= {tdi_in, tms_in, tck_in};
      sync_b_r <= sync_a_r;
      tck_d_r <= sync_b_r[0];
    end
  end

  assign tck_s = sync_b_r[0];
  assign tms_s = sync_b_r[1];
  assign tdi_s = sync_b_r[2];
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // ----------------------------------------------------------------
  // Memory and port enable
  // ----------------------------------------------------------------
  jtip_mem_if mem_bus ();

  jtip_row_mem u_mem (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .bus     (mem_bus.mem)
  );

  logic port_en;
  // Factory-erased configuration keeps the pins as the port
  assign port_en = ~mem_bus.cfg_off;
  // Pin macrocells are never gated here, so buried logic keeps working
  assign port_jtag_out = port_en;

  // ----------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------
  jtip_tap_t tap_r;
  jtip_tap_t tap_nxt;

  always_comb begin
    tap_nxt = tap_r;
    unique case (tap_r)
      TS_RESET: tap_nxt = tms_s ? TS_RESET : TS_IDLE;
      TS_IDLE: tap_nxt = tms_s ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: tap_nxt = tms_s ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: tap_nxt = tms_s ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: tap_nxt = tms_s ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: tap_nxt = tms_s ? TS_UP_DR : TS_PA_DR;
      TS_PA_DR: tap_nxt = tms_s ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: tap_nxt = tms_s ? TS_UP_DR : TS_SH_DR;
      TS_UP_DR: tap_nxt = tms_s ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: tap_nxt = tms_s ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: tap_nxt = tms_s ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: tap_nxt = tms_s ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: tap_nxt = tms_s ? TS_UP_IR : TS_PA_IR;
      TS_PA_IR: tap_nxt = tms_s ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: tap_nxt = tms_s ? TS_UP_IR : TS_SH_IR;
      TS_UP_IR: tap_nxt = tms_s ? TS_SEL_DR : TS_IDLE;
      default: tap_nxt = TS_RESET;
    endcase
  end

  // No test reset pin: power-up reset or a disabled port forces reset
  always_ff @(posedge mclk_in) begin
    if (rst_in || !port_en) begin
      tap_r <= TS_RESET;
    end else if (tck_rise) begin
      tap_r <= tap_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_sr_r;
  logic [IR_W-1:0] ir_r;
  jtip_dsel_t dsel;
  logic is_prg_code;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ir_sr_r <= IR_CAPTURE;
    end else if (tck_rise && tap_r == TS_CAP_IR) begin
      ir_sr_r <= IR_CAPTURE;
    end else if (tck_rise && tap_r == TS_SH_IR) begin
      ir_sr_r <= {tdi_s, ir_sr_r[IR_W-1:1]};
    end
  end

  // All-ones scanned in lands here as the bypass code
  always_ff @(posedge mclk_in) begin
    if (rst_in || tap_r == TS_RESET) begin
      ir_r <= IR_RESET_VAL;
    end else if (tck_rise && tap_r == TS_UP_IR) begin
      ir_r <= ir_sr_r;
    end
  end

  always_comb begin
    unique case (ir_r)
      IR_IDCODE: dsel = DS_ID;
      IR_ENABLE, IR_ERASE, IR_PROGRAM, IR_VERIFY: dsel = DS_PRG;
      default: dsel = DS_BYP;
    endcase
  end

  assign is_prg_code = (ir_sr_r == IR_ENABLE) || (ir_sr_r == IR_ERASE)
                    || (ir_sr_r == IR_PROGRAM) || (ir_sr_r == IR_VERIFY);

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  // One shift chain serves all three; its length follows the selection
  logic [ID_W-1:0] dr_sr_r;
  logic [ADDR_W-1:0] row_addr_r;
  logic armed_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      dr_sr_r <= DR_RESET_VAL;
    end else if (tck_rise && tap_r == TS_CAP_DR) begin
      unique case (dsel)
        DS_BYP: dr_sr_r <= DR_RESET_VAL;
        DS_ID: dr_sr_r <= IDCODE_VAL;
        DS_PRG: begin
          if (ir_r == IR_VERIFY && armed_r) begin
            dr_sr_r <= ID_W'({row_addr_r, mem_bus.rd_data});
          end
        end
      endcase
    end else if (tck_rise && tap_r == TS_SH_DR) begin
      unique case (dsel)
        DS_BYP: dr_sr_r <= {dr_sr_r[ID_W-1:1], tdi_s};
        DS_ID: dr_sr_r <= {tdi_s, dr_sr_r[ID_W-1:1]};
        DS_PRG: begin
          dr_sr_r <= {{(ID_W-PRG_W){1'b0}}, tdi_s,
                      dr_sr_r[PRG_W-1:1]};
        end
      endcase
    end
  end

  // Programming register holds row address above the row data
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      row_addr_r <= CFG_ROW;
    end else if (tck_rise && tap_r == TS_UP_DR && dsel == DS_PRG) begin
      row_addr_r <= dr_sr_r[PRG_W-1:DATA_W];
    end
  end

  // Arming survives a run of programming instructions only
  always_ff @(posedge mclk_in) begin
    if (rst_in || tap_r == TS_RESET) begin
      armed_r <= 1'b0;
    end else if (tck_rise && tap_r == TS_UP_IR) begin
      armed_r <= (ir_sr_r == IR_ENABLE)
              || (armed_r && is_prg_code);
    end
  end

  // ----------------------------------------------------------------
  // Erase and program pulses
  // ----------------------------------------------------------------
  // Pump timing is held on chip; the host only waits it out
  jtip_op_t op_r;
  logic [CNT_W-1:0] op_cnt_r;
  logic [CNT_W-1:0] op_len_r;
  logic [ADDR_W-1:0] prog_addr_r;
  logic [DATA_W-1:0] prog_data_r;
  logic op_start;
  logic op_done;

  assign op_start = tck_rise && tap_r == TS_UP_DR && armed_r
                 && op_r == OP_IDLE
                 && (ir_r == IR_ERASE || ir_r == IR_PROGRAM);
  assign op_done = (op_r != OP_IDLE) && (op_cnt_r == op_len_r);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      op_r <= OP_IDLE;
      op_cnt_r <= '0;
      op_len_r <= '0;
      prog_addr_r <= CFG_ROW;
      prog_data_r <= ROW_ERASED;
    end else if (op_start) begin
      op_r <= (ir_r == IR_ERASE) ? OP_ERASE : OP_PROG;
      op_cnt_r <= '0;
      op_len_r <= (ir_r == IR_ERASE) ? CNT_W'(ERASE_CYC - 1)
                                     : CNT_W'(PROG_CYC - 1);
      // Row address latches on this same edge, so take it from the chain
      prog_addr_r <= dr_sr_r[PRG_W-1:DATA_W];
      prog_data_r <= dr_sr_r[DATA_W-1:0];
    end else if (op_done) begin
      op_r <= OP_IDLE;
    end else if (op_r != OP_IDLE) begin
      op_cnt_r <= op_cnt_r + CNT_W'(1);
    end
  end

  assign mem_bus.erase = op_done && op_r == OP_ERASE;
  assign mem_bus.we = op_done && op_r == OP_PROG;
  assign mem_bus.wr_addr = prog_addr_r;
  assign mem_bus.wr_data = prog_data_r;
  assign mem_bus.rd_addr = row_addr_r;
  assign hv_pump_on_out = ~op_r[0];

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  logic tdo_r;
  logic tdo_oe_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in || !port_en) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      if (tap_r == TS_SH_IR) begin
        tdo_r <= ir_sr_r[0];
        tdo_oe_r <= 1'b1;
      end else if (tap_r == TS_SH_DR) begin
        tdo_r <= dr_sr_r[0];
        tdo_oe_r <= 1'b1;
      end else begin
        tdo_oe_r <= 1'b0;
      end
    end
  end

  assign tdo_out = tdo_r;
  assign tdo_oe_out = tdo_oe_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  chk_byp_one_bit: assert property (
    (tck_rise && tap_r == TS_SH_DR && dsel == DS_BYP) |=>
      (dr_sr_r[0] == $past(tdi_s))
      && (dr_sr_r[ID_W-1:1] == $past(dr_sr_r[ID_W-1:1])))
    else $error("bypass path is not one bit");

  chk_id_capture: assert property (
    (tck_rise && tap_r == TS_CAP_DR && dsel == DS_ID) |=>
      dr_sr_r == IDCODE_VAL)
    else $error("identification value not captured");

  chk_dr_on_rise: assert property (
    ($changed(dr_sr_r) && !$past(rst_in)) |-> $past(tck_rise))
    else $error("data register moved without clock rise");

  chk_tdo_on_fall: assert property (
    (($changed(tdo_r) || $rose(tdo_oe_r)) && !$past(rst_in))
      |-> ($past(tck_fall) || $past(!port_en)))
    else $error("serial output moved without clock fall");

  chk_tdo_idle_off: assert property (
    (tck_fall && tap_r != TS_SH_DR && tap_r != TS_SH_IR) |=>
      !tdo_oe_r)
    else $error("serial output driven outside shift");

  chk_reset_state: assert property (
    $fell(rst_in) |-> (tap_r == TS_RESET && ir_r == IR_RESET_VAL))
    else $error("controller not reset by power-up reset");

  chk_ir_lsb_first: assert property (
    (tck_rise && tap_r == TS_SH_IR) |=>
      ir_sr_r == {$past(tdi_s), $past(ir_sr_r[IR_W-1:1])})
    else $error("instruction not shifted lsb first");

  chk_unknown_byp: assert property (
    (tck_rise && tap_r == TS_UP_IR && !is_prg_code
      && ir_sr_r != IR_IDCODE) |=> dsel == DS_BYP)
    else $error("unknown instruction not treated as bypass");

  chk_gpio_no_port: assert property (
    mem_bus.cfg_off |=> (tap_r == TS_RESET && !tdo_oe_r))
    else $error("port active after being configured off");

  chk_op_needs_arm: assert property (
    $rose(hv_pump_on_out) |-> ($past(armed_r)
      && ($past(ir_r) == IR_ERASE || $past(ir_r) == IR_PROGRAM)))
    else $error("array pulse started without arming");

  cov_byp_shift: cover property (
    tck_rise && tap_r == TS_SH_DR && dsel == DS_BYP);
  cov_id_capture: cover property (
    tck_rise && tap_r == TS_CAP_DR && dsel == DS_ID);
  cov_erase_done: cover property (mem_bus.erase);
  cov_prog_done: cover property (mem_bus.we);

endmodule : jtip_top
`default_nettype wire

// ---- jtip_host.sv ----
// Scan host model that drives the test port pins of the device
`timescale 1ns/1ns
`default_nettype none
module jtip_host (
  // Clock used to pace the test clock
  input wire logic mclk_in,
  // Port pins
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Test clock stands low between frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // ----------------------------------------------------------------
  // Pin sequencing
  // ----------------------------------------------------------------
  // One 80 ns period, low half first; data out read just before rise
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge mclk_in);
    #1;
    tms_out = m;
    tdi_out = d;
    repeat (4) @(posedge mclk_in);
    #1;
    o = tdo_in;
    tck_out = 1'b1;
    repeat (5) @(posedge mclk_in);
    #1;
    tck_out = 1'b0;
  endtask : tick

  task automatic to_idle();
    logic o;
    repeat (5) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tms_out = 1'b1;
  endtask : to_idle

  // Idle to idle; serial input held high outside the shift bits
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b1, o);
    if (ir) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tms_out = 1'b1;
  endtask : scan
endmodule : jtip_host
`default_nettype wire

// ---- jtip_top_tb.sv ----
// Self-checking bench for the test access port
`timescale 1ns/1ns
`default_nettype none
module jtip_top_tb;
  import jtip_pkg::*;
  // Short pulses keep the run brief
  localparam int unsigned ERASE_T = 20;
  localparam int unsigned PROG_T = 10;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic tck, tms, tdi;
  logic tdo_out, tdo_oe_out, port_jtag_out, hv_pump_on_out;
  wire logic tdo_pin;
  logic [31:0] got;
  int bad_count = 0;
  int n_tests = 0;
  int pump_len = 0;

  // Pin has a pull-up, so a released output reads high
  assign tdo_pin = (tdo_oe_out === 1'b1) ? tdo_out : 1'b1;

  always #4 mclk_in = ~mclk_in;

  always @(posedge mclk_in) begin
    if (hv_pump_on_out === 1'b1) pump_len <= pump_len + 1;
  end

  jtip_top #(.ERASE_CYC(ERASE_T), .PROG_CYC(PROG_T)) dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
    .port_jtag_out(port_jtag_out), .hv_pump_on_out(hv_pump_on_out));

  jtip_host host (.mclk_in(mclk_in), .tck_out(tck), .tms_out(tms),
                  .tdi_out(tdi), .tdo_in(tdo_pin));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_val

  task automatic ir(input logic [3:0] code);
    host.scan(1'b1, 4, {28'h0, code}, got);
  endtask : ir

  task automatic dr(input int n, input logic [31:0] d);
    host.scan(1'b0, n, d, got);
  endtask : dr

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check_val("oe after reset", 32'h0, tdo_oe_out);
    check_val("port after reset", 32'h1, port_jtag_out);
    check_val("pump after reset", 32'h0, hv_pump_on_out);
    host.to_idle();
    $display("test reset done");
  endtask : t_reset

  task automatic t_ident();
    dr(32, 32'h0);
    check_val("ident at reset", IDCODE_VAL, got);
    ir(IR_IDCODE);
    check_val("ir capture", 32'h1, got);
    dr(32, 32'hffff_ffff);
    check_val("ident shift", IDCODE_VAL, got);
    check_val("oe idle", 32'h0, tdo_oe_out);
    $display("test ident done");
  endtask : t_ident

  task automatic t_bypass();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      if (c inside {4'h1, 4'h9, 4'ha, 4'hb, 4'hc}) continue;
      ir(c);
      dr(8, 32'hb5);
      // One-bit register delays the stream by one clock
      check_val("bypass stream", 32'h6a, got);
    end
    $display("test bypass done");
  endtask : t_bypass

  task automatic t_program();
    ir(IR_ENABLE);
    ir(IR_ERASE);
    pump_len = 0;
    dr(20, 32'h0);
    repeat (40) @(posedge mclk_in);
    check_val("erase pulse", ERASE_T, pump_len);
    ir(IR_PROGRAM);
    pump_len = 0;
    dr(20, 32'h3_c3a5);
    repeat (40) @(posedge mclk_in);
    check_val("program pulse", PROG_T, pump_len);
    ir(IR_VERIFY);
    dr(20, 32'h3_0000);
    dr(20, 32'h0);
    check_val("verify row", 32'h3_c3a5, got);
    $display("test program done");
  endtask : t_program

  task automatic t_unarmed();
    ir(IR_BYPASS);
    ir(IR_PROGRAM);
    pump_len = 0;
    dr(20, 32'h7_ffff);
    repeat (40) @(posedge mclk_in);
    check_val("unarmed pulse", 32'h0, pump_len);
    ir(IR_ENABLE);
    ir(IR_VERIFY);
    dr(20, 32'h7_0000);
    dr(20, 32'h0);
    check_val("unarmed row", 32'h7_0000, got);
    $display("test unarmed done");
  endtask : t_unarmed

  task automatic t_cfg_off();
    ir(IR_ENABLE);
    ir(IR_PROGRAM);
    dr(20, 32'h0_0001);
    repeat (40) @(posedge mclk_in);
    check_val("port mode", 32'h0, port_jtag_out);
    // Pins now plain I/O: scan traffic must be ignored
    dr(32, 32'h0);
    check_val("released out", 32'hffff_ffff, got);
    $display("test config off done");
  endtask : t_cfg_off

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    t_reset();
    t_ident();
    t_bypass();
    t_program();
    t_unarmed();
    t_cfg_off();
    conclude();
  end

  initial begin
    #600_000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end
endmodule : jtip_top_tb
`default_nettype wire
